// file: cpu_regs_defines.svh
`ifndef CPU_REGS_DEFINES_SVH
`define CPU_REGS_DEFINES_SVH

// Flag byte bit positions.
`define FLAG_IMASK_BIT     7
`define FLAG_SPARE_BIT     6
`define FLAG_HALF_BIT      5
`define FLAG_NEG_BIT       3
`define FLAG_ZERO_BIT      2
`define FLAG_OVF_BIT       1
`define FLAG_CARRY_BIT     0

// Half-carry tap positions per operand size.
`define HALF_TAP_BYTE      3
`define HALF_TAP_WORD      11
`define HALF_TAP_LONG      27

// Register counts and widths.
`define GPR_COUNT          8
`define STACK_GPR_INDEX    3'h7
`define FETCH_PTR_WIDTH    24
`define ADDR_SPACE_MASK    24'h00FFFF

// Execution state counts.
`define STATES_ADDSUB      2
`define STATES_MUL_8X8     14
`define STATES_MUL_16X16   22
`define STATES_DIV_16_8    14
`define STATES_DIV_32_16   22

`endif

// file: cpu_regs_pkg.sv
package cpu_regs_pkg;

   // Width of a general register access.
   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_WORD = 2'b01,
      SZ_LONG = 2'b10
   } size_type;

   // Flag byte operation selected by the core.
   typedef enum logic [2:0] {
      FOP_NONE  = 3'b000,
      FOP_LOAD  = 3'b001,
      FOP_AND   = 3'b010,
      FOP_OR    = 3'b011,
      FOP_XOR   = 3'b100,
      FOP_ARITH = 3'b101
   } flag_op_type;

   // Arithmetic operation whose flags are captured.
   typedef enum logic [2:0] {
      AOP_ADD  = 3'b000,
      AOP_ADDX = 3'b001,
      AOP_SUB  = 3'b010,
      AOP_SUBX = 3'b011,
      AOP_CMP  = 3'b100,
      AOP_NEG  = 3'b101
   } arith_op_type;

   // Multi-state operation kinds for the busy timer.
   typedef enum logic [2:0] {
      XOP_NONE   = 3'b000,
      XOP_ADDSUB = 3'b001,
      XOP_MUL8   = 3'b010,
      XOP_MUL16  = 3'b011,
      XOP_DIV16  = 3'b100,
      XOP_DIV32  = 3'b101
   } exec_op_type;

   // One general register access, for read or write.
   typedef struct packed {
      logic [2:0] index;
      logic       hi_half;
      logic       hi_byte;
      size_type   size;
   } gpr_sel_type;

   // Condition inputs for conditional branches.
   typedef struct packed {
      logic neg;
      logic zero;
      logic ovf;
      logic carry;
   } branch_cond_type;

endpackage

// file: gpr_bank.sv
`timescale 1ns/10ps
`include "cpu_regs_defines.svh"

// Eight wide general registers with byte-lane write enables.
module gpr_bank (
   input  wire logic        sys_clk,    // Core clock.
   input  wire logic [2:0]  wr_index,   // Register written.
   input  wire logic [3:0]  wr_lanes,   // Byte lanes written.
   input  wire logic [31:0] wr_data,    // Aligned write data.
   input  wire logic [2:0]  rd_index,   // Register read.
   output logic      [31:0] rd_data,    // Registered read data.
   output logic      [31:0] stack_word  // Live stack register value.
);
   // Each byte lane owns its storage, so no two processes write one array.
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : lane
         logic [7:0] mem_r [`GPR_COUNT];

         // Only enabled lanes change, so narrow views leave the rest intact.
         always_ff @(posedge sys_clk) begin
            if (wr_lanes[g]) begin
               mem_r[wr_index] <= wr_data[8*g +: 8];
            end
         end

         // Read port is registered; a same-cycle write returns the old value.
         always_ff @(posedge sys_clk) begin
            rd_data[8*g +: 8] <= mem_r[rd_index];
         end

         assign stack_word[8*g +: 8] = mem_r[`STACK_GPR_INDEX];
      end
   endgenerate
endmodule

// file: cpu_register_file_ccr.sv
`timescale 1ns/10ps
`include "cpu_regs_defines.svh"

// Function
// - Eight identical 32-bit general registers, address or data use.
// - Each wide register splits into independent extended and base 16-bit halves.
// - Each base half splits into separately addressable high and low bytes.
// - Access width is chosen per access, independent of other registers.
// - Register seven doubles as stack pointer for exceptions and calls.
// - 24-bit fetch pointer; bit zero reads as zero on fetch.
// - Reset exception loads the fetch pointer from the reset vector.
// - Reset sets the interrupt mask bit; other flag bits stay uninitialised.
// - Mask bit set blocks maskable interrupts; unmaskable always accepted.
// - Every exception sequence start sets the interrupt mask bit.
// - Flag bit six is a spare bit with no hardware effect.
// - Flag byte loadable, storable, and AND/OR/XOR modifiable; may stay unchanged.
// - Negative, zero, overflow and carry feed conditional branches.
// - Byte arithmetic sets half-carry from carry or borrow out of bit 3.
// - Word arithmetic sets half-carry from carry or borrow out of bit 11.
// - Long arithmetic sets half-carry from carry or borrow out of bit 27.
// - Normal mode only; addresses limited to 64 kilobytes.
// - Register add and subtract take 2 states at all sizes.
// - An 8-by-8 multiply takes 14 states.
// - A 16-by-16 multiply takes 22 states.
// - A 16-by-8 divide takes 14 states.
// - A 32-by-16 divide takes 22 states.
// - Negative flag takes the result's most significant bit.
// - Zero flag cleared on a nonzero result; a zero result sets it, or leaves it unchanged for extend ops.
// - Overflow flag set on arithmetic overflow, cleared otherwise.
// - Carry flag records carry and borrow of add, subtract, compare and negate.
module cpu_register_file_ccr (
   input  wire logic                          sys_clk,       // Core clock, 20 MHz.
   input  wire logic                          srst,          // Synchronous reset, high.
   input  wire cpu_regs_pkg::gpr_sel_type     gpr_wr_sel,    // Write register and view.
   input  wire logic                          gpr_wr_en,     // Write strobe.
   input  wire logic [31:0]                   gpr_wr_data,   // Write data, low aligned.
   input  wire cpu_regs_pkg::gpr_sel_type     gpr_rd_sel,    // Read register and view.
   output logic      [31:0]                   gpr_rd_data,   // Read data, low aligned.
   input  wire logic                          sp_wr_en,      // Implicit stack write.
   input  wire logic [31:0]                   sp_wr_data,    // New stack pointer.
   output logic      [31:0]                   stack_top_ptr, // Stack pointer value.
   input  wire logic                          vector_load,   // Reset vector fetched.
   input  wire logic [23:0]                   vector_data,   // Start address.
   input  wire logic                          fetch_ptr_wr,  // Branch or jump load.
   input  wire logic [23:0]                   fetch_ptr_in,  // New fetch address.
   input  wire logic                          fetch_adv,     // Advance one word.
   output logic      [23:0]                   fetch_ptr,     // Fetch pointer register.
   output logic      [23:0]                   fetch_addr,    // Fetch address, bit 0 low.
   input  wire cpu_regs_pkg::flag_op_type     flag_op,       // Flag byte operation.
   input  wire logic [7:0]                    flag_operand,  // Load or logic operand.
   input  wire cpu_regs_pkg::arith_op_type    arith_op,      // Arithmetic kind.
   input  wire cpu_regs_pkg::size_type        arith_size,    // Operand size.
   input  wire logic [31:0]                   arith_a,       // Destination operand.
   input  wire logic [31:0]                   arith_b,       // Source operand.
   input  wire logic                          exc_start,     // Exception sequence begins.
   input  wire logic                          irq_req,       // Maskable interrupt request.
   input  wire logic                          unmask_req,    // Unmaskable interrupt request.
   output logic                               irq_accept,    // Interrupt accepted.
   output logic      [7:0]                    flag_byte,     // Flag byte, for store.
   output cpu_regs_pkg::branch_cond_type      branch_cond,   // Branch conditions.
   input  wire cpu_regs_pkg::exec_op_type     exec_op,       // Start multi-state op.
   output logic                               exec_busy,     // Operation in progress.
   output logic                               exec_done      // Final state pulse.
);
   import cpu_regs_pkg::*;

   logic [3:0]  wr_lanes;
   logic [31:0] wr_aligned;
   logic [2:0]  bank_wr_index;
   logic [3:0]  bank_lanes;
   logic [31:0] bank_wr_data;
   logic [31:0] bank_rd_word;
   logic [31:0] stack_word;
   gpr_sel_type rd_sel_r;

   // Map the selected view onto byte lanes of the wide register.
   always_comb begin
      wr_lanes   = 4'h0;
      wr_aligned = 32'h0;
      unique case (gpr_wr_sel.size)
         SZ_LONG: begin
            wr_lanes   = 4'hF;
            wr_aligned = gpr_wr_data;
         end
         SZ_WORD: begin
            wr_lanes   = gpr_wr_sel.hi_half ? 4'hC : 4'h3;
            wr_aligned = {gpr_wr_data[15:0], gpr_wr_data[15:0]};
         end
         SZ_BYTE: begin
            wr_lanes   = gpr_wr_sel.hi_byte ? 4'h2 : 4'h1;
            wr_aligned = {4{gpr_wr_data[7:0]}};
         end
         default: begin
            wr_lanes   = 4'h0;
            wr_aligned = 32'h0;
         end
      endcase
   end

   // Implicit stack writes win over a normal write in the same cycle.
   always_comb begin
      if (sp_wr_en) begin
         bank_wr_index = `STACK_GPR_INDEX;
         bank_lanes    = 4'hF;
         bank_wr_data  = sp_wr_data;
      end else begin
         bank_wr_index = gpr_wr_sel.index;
         bank_lanes    = gpr_wr_en ? wr_lanes : 4'h0;
         bank_wr_data  = wr_aligned;
      end
   end

   gpr_bank gpr_bank_i (
      .sys_clk    (sys_clk),
      .wr_index   (bank_wr_index),
      .wr_lanes   (bank_lanes),
      .wr_data    (bank_wr_data),
      .rd_index   (gpr_rd_sel.index),
      .rd_data    (bank_rd_word),
      .stack_word (stack_word)
   );

   // The view select is delayed to line up with the registered read word.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rd_sel_r <= '0;
      end else begin
         rd_sel_r <= gpr_rd_sel;
      end
   end

   // Narrow reads come back zero-extended in the low bits.
   always_comb begin
      unique case (rd_sel_r.size)
         SZ_WORD: gpr_rd_data = {16'h0000, rd_sel_r.hi_half ? bank_rd_word[31:16]
                                                            : bank_rd_word[15:0]};
         SZ_BYTE: gpr_rd_data = {24'h000000, rd_sel_r.hi_byte ? bank_rd_word[15:8]
                                                              : bank_rd_word[7:0]};
         default: gpr_rd_data = bank_rd_word;
      endcase
   end

   assign stack_top_ptr = stack_word;

   // Fetch pointer: vector load has priority, then jumps, then advance.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fetch_ptr <= 24'h000000;
      end else if (vector_load) begin
         fetch_ptr <= vector_data & `ADDR_SPACE_MASK;
      end else if (fetch_ptr_wr) begin
         fetch_ptr <= fetch_ptr_in & `ADDR_SPACE_MASK;
      end else if (fetch_adv) begin
         fetch_ptr <= (fetch_ptr + 24'h000002) & `ADDR_SPACE_MASK;
      end
   end

   // Instructions are one word long, so the odd address bit is ignored.
   assign fetch_addr = {fetch_ptr[23:1], 1'b0};

   // Arithmetic flag results; the half-carry tap moves with operand size.
   logic [32:0] sum_full;
   logic [31:0] rhs;
   logic        cin;
   logic        is_sub;
   logic [31:0] res;
   logic        msb_a;
   logic        msb_b;
   logic        msb_r;
   logic        c_out;
   logic        h_out;
   logic        z_out;
   logic        v_out;
   logic [31:0] lo_a;
   logic [31:0] lo_b;
   logic [31:0] lo_sum;
   logic [31:0] size_mask;
   logic [4:0]  h_tap;
   logic [4:0]  top_bit;

   always_comb begin
      is_sub = (arith_op == AOP_SUB) || (arith_op == AOP_SUBX) ||
               (arith_op == AOP_CMP) || (arith_op == AOP_NEG);
      cin    = ((arith_op == AOP_ADDX) || (arith_op == AOP_SUBX)) ?
               flag_byte[`FLAG_CARRY_BIT] : 1'b0;
      unique case (arith_size)
         SZ_BYTE: begin
            size_mask = 32'h000000FF;
            h_tap     = 5'(`HALF_TAP_BYTE);
            top_bit   = 5'h07;
         end
         SZ_WORD: begin
            size_mask = 32'h0000FFFF;
            h_tap     = 5'(`HALF_TAP_WORD);
            top_bit   = 5'h0F;
         end
         default: begin
            size_mask = 32'hFFFFFFFF;
            h_tap     = 5'(`HALF_TAP_LONG);
            top_bit   = 5'h1F;
         end
      endcase
      // Negate is zero minus the operand in the destination position.
      lo_a = (arith_op == AOP_NEG) ? 32'h0 : (arith_a & size_mask);
      lo_b = ((arith_op == AOP_NEG) ? arith_a : arith_b) & size_mask;
      rhs  = is_sub ? (~lo_b & size_mask) : lo_b;
      sum_full = {1'b0, lo_a} + {1'b0, rhs} + {32'h0, is_sub ^ cin};
      res      = sum_full[31:0] & size_mask;
      // Carry out of a bit is the sum bit above it xor the operand bits there.
      lo_sum = lo_a ^ rhs ^ sum_full[31:0];
      h_out  = lo_sum[h_tap + 5'h01] ^ is_sub;
      c_out  = (top_bit == 5'h1F) ? sum_full[32] : lo_sum[top_bit + 5'h01];
      c_out  = c_out ^ is_sub;
      msb_a  = lo_a[top_bit];
      msb_b  = rhs[top_bit];
      msb_r  = res[top_bit];
      v_out  = (msb_a == msb_b) && (msb_r != msb_a);
      // Extend operations keep zero only if it was already set.
      z_out  = (res == 32'h0) && (((arith_op != AOP_ADDX) && (arith_op != AOP_SUBX)) ||
               flag_byte[`FLAG_ZERO_BIT]);
   end

   // Flag byte: mask bit reset to one; the rest keep their power-on value.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flag_byte[`FLAG_IMASK_BIT] <= 1'b1;
      end else if (exc_start) begin
         flag_byte[`FLAG_IMASK_BIT] <= 1'b1;
      end else begin
         unique case (flag_op)
            FOP_LOAD: flag_byte[`FLAG_IMASK_BIT] <= flag_operand[`FLAG_IMASK_BIT];
            FOP_AND:  flag_byte[`FLAG_IMASK_BIT] <= flag_byte[`FLAG_IMASK_BIT] &
                                                    flag_operand[`FLAG_IMASK_BIT];
            FOP_OR:   flag_byte[`FLAG_IMASK_BIT] <= flag_byte[`FLAG_IMASK_BIT] |
                                                    flag_operand[`FLAG_IMASK_BIT];
            FOP_XOR:  flag_byte[`FLAG_IMASK_BIT] <= flag_byte[`FLAG_IMASK_BIT] ^
                                                    flag_operand[`FLAG_IMASK_BIT];
            default:  flag_byte[`FLAG_IMASK_BIT] <= flag_byte[`FLAG_IMASK_BIT];
         endcase
      end
   end

   // Lower seven bits are not reset, so software must load them before use.
   always_ff @(posedge sys_clk) begin
      unique case (flag_op)
         FOP_LOAD: flag_byte[6:0] <= flag_operand[6:0];
         FOP_AND:  flag_byte[6:0] <= flag_byte[6:0] & flag_operand[6:0];
         FOP_OR:   flag_byte[6:0] <= flag_byte[6:0] | flag_operand[6:0];
         FOP_XOR:  flag_byte[6:0] <= flag_byte[6:0] ^ flag_operand[6:0];
         FOP_ARITH: begin
            flag_byte[`FLAG_HALF_BIT]  <= h_out;
            flag_byte[`FLAG_NEG_BIT]   <= msb_r;
            flag_byte[`FLAG_ZERO_BIT]  <= z_out;
            flag_byte[`FLAG_OVF_BIT]   <= v_out;
            flag_byte[`FLAG_CARRY_BIT] <= c_out;
         end
         default:  flag_byte[6:0] <= flag_byte[6:0];
      endcase
   end

   assign branch_cond = '{neg:   flag_byte[`FLAG_NEG_BIT],
                          zero:  flag_byte[`FLAG_ZERO_BIT],
                          ovf:   flag_byte[`FLAG_OVF_BIT],
                          carry: flag_byte[`FLAG_CARRY_BIT]};

   // Unmaskable requests ignore the mask bit entirely.
   assign irq_accept = unmask_req | (irq_req & ~flag_byte[`FLAG_IMASK_BIT]);

   // Multi-state operation timer: counts down the documented state count.
   logic [4:0] exec_cnt_r;
   logic [4:0] exec_len;

   always_comb begin
      unique case (exec_op)
         XOP_ADDSUB: exec_len = 5'(`STATES_ADDSUB);
         XOP_MUL8:   exec_len = 5'(`STATES_MUL_8X8);
         XOP_MUL16:  exec_len = 5'(`STATES_MUL_16X16);
         XOP_DIV16:  exec_len = 5'(`STATES_DIV_16_8);
         XOP_DIV32:  exec_len = 5'(`STATES_DIV_32_16);
         default:    exec_len = 5'h00;
      endcase
   end

   // A new start is ignored while busy so a running count is never cut short.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         exec_cnt_r <= 5'h00;
      end else if (exec_cnt_r != 5'h00) begin
         exec_cnt_r <= exec_cnt_r - 5'h01;
      end else if (exec_len != 5'h00) begin
         exec_cnt_r <= exec_len - 5'h01;
      end
   end

   assign exec_busy = (exec_cnt_r != 5'h00) || (exec_len != 5'h00);
   assign exec_done = (exec_cnt_r == 5'h01);
endmodule

// file: cpu_register_file_ccr_chk.sv
`timescale 1ns/10ps
// Watches the ports of the register file for flag, fetch and timing relations.
module cpu_register_file_ccr_chk (
   input wire logic                        sys_clk,       // Core clock.
   input wire logic                        srst,          // Synchronous reset.
   input wire logic                        sp_wr_en,      // Stack write.
   input wire logic [31:0]                 sp_wr_data,    // Stack data.
   input wire logic [31:0]                 stack_top_ptr, // Stack value.
   input wire logic                        vector_load,   // Vector load.
   input wire logic [23:0]                 vector_data,   // Start address.
   input wire logic [23:0]                 fetch_ptr,     // Fetch pointer.
   input wire logic [23:0]                 fetch_addr,    // Fetch address.
   input wire cpu_regs_pkg::flag_op_type   flag_op,       // Flag operation.
   input wire logic [7:0]                  flag_operand,  // Flag operand.
   input wire logic                        exc_start,     // Exception start.
   input wire logic                        irq_req,       // Maskable request.
   input wire logic                        unmask_req,    // Unmaskable request.
   input wire logic                        irq_accept,    // Request accepted.
   input wire logic [7:0]                  flag_byte,     // Flag byte.
   input wire cpu_regs_pkg::branch_cond_type branch_cond, // Branch conditions.
   input wire cpu_regs_pkg::exec_op_type   exec_op,       // Operation start.
   input wire logic                        exec_busy,     // Operation busy.
   input wire logic                        exec_done      // Last state.
);
   import cpu_regs_pkg::*;
   logic        busy_r;
   logic        done_r;
   logic [4:0]  len_r;
   exec_op_type op_r;
   logic        fresh;
   logic [4:0]  cur_len;
   exec_op_type cur_op;
   logic [4:0]  need;

   // History of the timer; a new start is only legal once the last state has passed.
   always_ff @(posedge sys_clk) begin
      busy_r <= srst ? 1'b0 : exec_busy;
      done_r <= srst ? 1'b0 : exec_done;
      len_r  <= srst ? 5'h00 : cur_len;
      op_r   <= srst ? XOP_NONE : cur_op;
   end

   // State count reached so far and the count the running operation needs.
   assign fresh = exec_busy && (!busy_r || done_r);
   assign cur_len = fresh ? 5'h01 : len_r + 5'h01;
   assign cur_op = fresh ? exec_op : op_r;
   always_comb begin
      case (cur_op)
         XOP_ADDSUB: need = 5'h02;
         XOP_MUL8, XOP_DIV16: need = 5'h0E;
         default: need = 5'h16;
      endcase
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_reset_mask; $fell(srst) |-> flag_byte[7]; endproperty
   a_reset_mask: assert property (p_reset_mask) else $error("mask bit clear after reset");
   property p_exc_mask; exc_start |=> flag_byte[7]; endproperty
   a_exc_mask: assert property (p_exc_mask) else $error("mask bit not set by exception");
   property p_irq; irq_accept == (unmask_req || (irq_req && !flag_byte[7])); endproperty
   a_irq: assert property (p_irq) else $error("interrupt acceptance wrong");
   property p_branch; branch_cond === flag_byte[3:0]; endproperty
   a_branch: assert property (p_branch) else $error("branch conditions wrong");
   property p_load;
      flag_op == FOP_LOAD && !exc_start |=> flag_byte == $past(flag_operand);
   endproperty
   a_load: assert property (p_load) else $error("flag load wrong");
   property p_xor;
      flag_op == FOP_XOR && !exc_start |=> flag_byte == ($past(flag_byte) ^ $past(flag_operand));
   endproperty
   a_xor: assert property (p_xor) else $error("flag xor wrong");
   property p_vec; vector_load |=> fetch_ptr == ($past(vector_data) & 24'h00FFFF); endproperty
   a_vec: assert property (p_vec) else $error("vector load wrong");
   property p_align; fetch_addr == {fetch_ptr[23:1], 1'b0}; endproperty
   a_align: assert property (p_align) else $error("fetch address not aligned");
   property p_stack; sp_wr_en |=> stack_top_ptr == $past(sp_wr_data); endproperty
   a_stack: assert property (p_stack) else $error("stack pointer write lost");
   property p_states; exec_busy |-> (exec_done == (cur_len == need)); endproperty
   a_states: assert property (p_states) else $error("state count wrong");
   property p_take; exec_op != XOP_NONE && (!busy_r || done_r) |-> exec_busy; endproperty
   a_take: assert property (p_take) else $error("operation start not taken");

   c_done: cover property (exec_done && cur_op == XOP_MUL16);
   c_masked: cover property (irq_req && flag_byte[7] && !irq_accept);
   c_vec: cover property (vector_load);
endmodule

bind cpu_register_file_ccr cpu_register_file_ccr_chk cpu_register_file_ccr_chk_i (.*);

// file: cpu_register_file_ccr_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the register file; inputs move 2 ns after each rising edge.
module cpu_register_file_ccr_tb;
   import cpu_regs_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   gpr_sel_type gpr_wr_sel, gpr_rd_sel;
   logic gpr_wr_en, sp_wr_en, vector_load, fetch_ptr_wr, fetch_adv;
   logic exc_start, irq_req, unmask_req, irq_accept, exec_busy, exec_done;
   logic [31:0] gpr_wr_data, gpr_rd_data, sp_wr_data, stack_top_ptr, arith_a, arith_b;
   logic [23:0] vector_data, fetch_ptr_in, fetch_ptr, fetch_addr;
   logic [7:0] flag_operand, flag_byte;
   flag_op_type flag_op;
   arith_op_type arith_op;
   size_type arith_size;
   branch_cond_type branch_cond;
   exec_op_type exec_op;
   int fail_count = 0;
   int checks = 0;

   // Free-running 20 MHz core clock.
   always #25 sys_clk = ~sys_clk;

   cpu_register_file_ccr cpu_register_file_ccr_i (.*);

   task automatic step();
      @(posedge sys_clk);
      #2;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic close_out();
      if (fail_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // One register write; the strobe drops for a cycle so writes never merge.
   task automatic wr(input logic [2:0] ix, input logic hh, input logic hb, input size_type sz,
                     input logic [31:0] d);
      gpr_wr_sel = '{ix, hh, hb, sz};
      gpr_wr_data = d;
      gpr_wr_en = 1'b1;
      step();
      gpr_wr_en = 1'b0;
      step();
   endtask

   // The read select is sampled at an edge and the data stands in the next cycle.
   task automatic rd(input logic [2:0] ix, input logic hh, input logic hb, input size_type sz,
                     input logic [31:0] exp);
      gpr_rd_sel = '{ix, hh, hb, sz};
      step();
      chk("read data", exp, gpr_rd_data);
   endtask

   task automatic fop(input flag_op_type op, input logic [7:0] v);
      flag_op = op;
      flag_operand = v;
      step();
      flag_op = FOP_NONE;
      step();
   endtask

   // Bits 7, 6 and 4 are preloaded high so the arithmetic update must keep them.
   task automatic ar(input arith_op_type op, input size_type sz, input logic [31:0] a,
                     input logic [31:0] b, input logic [4:0] e);
      fop(FOP_LOAD, 8'hD0);
      arith_op = op;
      arith_size = sz;
      arith_a = a;
      arith_b = b;
      fop(FOP_ARITH, 8'h00);
      chk("arith flags", {24'h0, 2'b11, e[4], 1'b1, e[3:0]}, {24'h0, flag_byte});
   endtask

   // Counts busy states; a second start in the fourth state must be ignored.
   task automatic ex(input exec_op_type op, input int cnt);
      int n;
      int d;
      n = 0;
      d = 0;
      step();
      exec_op = op;
      repeat (26) begin
         #1;
         if (exec_busy === 1'b1) n++;
         if (exec_done === 1'b1) d = n;
         step();
         exec_op = (n == 3) ? XOP_DIV32 : XOP_NONE;
      end
      chk("busy states", cnt, n);
      chk("done state", cnt, d);
   endtask

   task automatic t_gpr();
      for (int i = 0; i < 8; i++) wr(3'(i), 1'b0, 1'b0, SZ_LONG, 32'h01010101 * (i + 1));
      for (int i = 0; i < 8; i++) rd(3'(i), 1'b0, 1'b0, SZ_LONG, 32'h01010101 * (i + 1));
      wr(3'h2, 1'b1, 1'b0, SZ_WORD, 32'h00005566);
      wr(3'h2, 1'b0, 1'b1, SZ_BYTE, 32'h000000AA);
      rd(3'h2, 1'b0, 1'b0, SZ_LONG, 32'h5566AA03);
      rd(3'h2, 1'b1, 1'b0, SZ_WORD, 32'h00005566);
      rd(3'h2, 1'b0, 1'b0, SZ_WORD, 32'h0000AA03);
      rd(3'h2, 1'b0, 1'b1, SZ_BYTE, 32'h000000AA);
      rd(3'h2, 1'b0, 1'b0, SZ_BYTE, 32'h00000003);
      rd(3'h3, 1'b0, 1'b0, SZ_LONG, 32'h04040404);
   endtask

   task automatic t_misc();
      sp_wr_en = 1'b1;
      sp_wr_data = 32'hCAFE0010;
      gpr_wr_sel = '{3'h7, 1'b0, 1'b0, SZ_LONG};
      gpr_wr_data = 32'h0;
      gpr_wr_en = 1'b1;
      step();
      sp_wr_en = 1'b0;
      gpr_wr_en = 1'b0;
      chk("stack pointer", 32'hCAFE0010, stack_top_ptr);
      rd(3'h7, 1'b0, 1'b0, SZ_LONG, 32'hCAFE0010);
      vector_load = 1'b1;
      vector_data = 24'h12ABCD;
      fetch_ptr_wr = 1'b1;
      fetch_ptr_in = 24'h000100;
      step();
      vector_load = 1'b0;
      fetch_ptr_wr = 1'b0;
      chk("fetch pointer", 32'h0000ABCD, {8'h0, fetch_ptr});
      fetch_adv = 1'b1;
      step();
      fetch_adv = 1'b0;
      chk("fetch pointer", 32'h0000ABCF, {8'h0, fetch_ptr});
      chk("fetch address", 32'h0000ABCE, {8'h0, fetch_addr});
   endtask

   task automatic t_flags();
      fop(FOP_LOAD, 8'h40);
      chk("flag byte", 32'h40, {24'h0, flag_byte});
      fop(FOP_OR, 8'h0A);
      fop(FOP_AND, 8'h0F);
      fop(FOP_XOR, 8'h41);
      chk("flag byte", 32'h4B, {24'h0, flag_byte});
      chk("branch conditions", 32'hB, {28'h0, branch_cond});
      irq_req = 1'b1;
      #1 chk("accept", 32'h1, {31'h0, irq_accept});
      step();
      exc_start = 1'b1;
      step();
      exc_start = 1'b0;
      chk("flag byte", 32'hCB, {24'h0, flag_byte});
      chk("accept", 32'h0, {31'h0, irq_accept});
      unmask_req = 1'b1;
      #1 chk("accept", 32'h1, {31'h0, irq_accept});
      step();
      unmask_req = 1'b0;
      irq_req = 1'b0;
   endtask

   task automatic t_arith();
      ar(AOP_ADD, SZ_BYTE, 32'h0F, 32'h01, 5'b10000);
      ar(AOP_ADD, SZ_BYTE, 32'h7F, 32'h01, 5'b11010);
      ar(AOP_ADD, SZ_BYTE, 32'hFF, 32'h01, 5'b10101);
      ar(AOP_ADDX, SZ_BYTE, 32'h08, 32'h08, 5'b10000);
      ar(AOP_SUB, SZ_BYTE, 32'h10, 32'h01, 5'b10000);
      ar(AOP_SUBX, SZ_BYTE, 32'h10, 32'h01, 5'b10000);
      ar(AOP_CMP, SZ_BYTE, 32'h05, 32'h05, 5'b00100);
      ar(AOP_NEG, SZ_BYTE, 32'h01, 32'h00, 5'b11001);
      ar(AOP_ADD, SZ_WORD, 32'h0FFF, 32'h0001, 5'b10000);
      ar(AOP_ADD, SZ_WORD, 32'h00FF, 32'h0001, 5'b00000);
      ar(AOP_SUB, SZ_WORD, 32'h1000, 32'h0001, 5'b10000);
      ar(AOP_CMP, SZ_WORD, 32'h8000, 32'h0001, 5'b10010);
      ar(AOP_NEG, SZ_WORD, 32'h0001, 32'h0000, 5'b11001);
      ar(AOP_ADD, SZ_LONG, 32'h0FFFFFFF, 32'h1, 5'b10000);
      ar(AOP_ADD, SZ_LONG, 32'h0000FFFF, 32'h1, 5'b00000);
      ar(AOP_SUB, SZ_LONG, 32'h10000000, 32'h1, 5'b10000);
      ar(AOP_CMP, SZ_LONG, 32'h1, 32'h1, 5'b00100);
      ar(AOP_NEG, SZ_LONG, 32'h0, 32'h0, 5'b00100);
   endtask

   // Hang guard, well past the run length.
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      close_out();
   end

   initial begin
      gpr_wr_sel = '{3'h0, 1'b0, 1'b0, SZ_LONG};
      gpr_rd_sel = '{3'h0, 1'b0, 1'b0, SZ_LONG};
      {gpr_wr_en, sp_wr_en, vector_load, fetch_ptr_wr, fetch_adv} = 5'h0;
      {exc_start, irq_req, unmask_req} = 3'h0;
      {gpr_wr_data, sp_wr_data, arith_a, arith_b} = 128'h0;
      {vector_data, fetch_ptr_in, flag_operand} = 56'h0;
      flag_op = FOP_NONE;
      arith_op = AOP_ADD;
      arith_size = SZ_BYTE;
      exec_op = XOP_NONE;
      repeat (6) @(posedge sys_clk);
      #2 srst = 1'b0;
      chk("mask bit", 32'h1, {31'h0, flag_byte[7]});
      chk("fetch pointer", 32'h0, {8'h0, fetch_ptr});
      t_gpr();
      t_misc();
      t_flags();
      t_arith();
      ex(XOP_ADDSUB, 2);
      ex(XOP_MUL8, 14);
      ex(XOP_MUL16, 22);
      ex(XOP_DIV16, 14);
      ex(XOP_DIV32, 22);
      close_out();
   end
endmodule
